// *** src/l1ci_fsm.v ***
`timescale 1ns/1ps
`default_nettype none
`include "l1ci_consts.vh"
// ==========================================
// Overview of operation
// - 1000 low-priority, 1001 high-priority activation
// - 1010 activates loop A, tx disable optional
// - command 0001 resets the state machine
// - command 0000 requests clocks to run
// - 0010 sends one pulse per frame
// - 0011 sends pulses continuously
// - data transparent when active; terminal side only while activation held
// - deactivation indicates 0000, or 0101 from sync
// - reset acks 0001, pulse tests ack 0010
// - signal without sync indicates 0100
// - clocks supplied after power-up indicate 0111
// - info2 1000, loop closed 1010, active 1110
// - illegal violation 1011 only when enabled
// - info4 gives 1100 or 1101 by priority
// - quiescent state stops clocks when selected
// - info1 repeats 00111111, info3 framed
// - receive classes info0, 2, 4, X
// - line side: command 1000 or 1010 during info0, or any signal, starts info2
// - line side: lost sync sends info2, resumes
// - deactivation after 16 ms info0 or 32 ms
// - hold final deactivation until confirm
module l1ci_fsm #(
	parameter INFO0_WAIT_CYC  = `L1CI_INFO0_WAIT_CYC,
	parameter DEACT_TIMER_CYC = `L1CI_DEACT_TIMER_CYC
) (
	input  wire       clock_i,
	input  wire       srst_i,
	input  wire       line_term_mode_i,
	input  wire       frame_strobe_i,
	input  wire [3:0] cmd_code_i,
	input  wire       rx_signal_i,
	input  wire       rx_sync_i,
	input  wire       rx_a_bit_i,
	input  wire       rx_high_prio_i,
	input  wire       rx_illegal_viol_i,
	input  wire       illegal_violation_enable_i,
	input  wire       transmit_disable_i,
	input  wire       clock_shutdown_select_i,
	output reg  [3:0] ind_code_o,
	output reg  [2:0] tx_info_o,
	output reg        tx_pattern_bit_o,
	output reg        loop_closed_o,
	output reg        loop_tx_blank_o,
	output reg        transparent_o,
	output reg        clocks_enable_o
);
	// ==========================================
	// states
	localparam [3:0] ST_RESET      = 4'h0;
	localparam [3:0] ST_DEACT      = 4'h1;
	localparam [3:0] ST_POWER_UP   = 4'h2;
	localparam [3:0] ST_PEND_ACT   = 4'h3;
	localparam [3:0] ST_UNSYNC     = 4'h4;
	localparam [3:0] ST_SYNC       = 4'h5;
	localparam [3:0] ST_ACTIVE     = 4'h6;
	localparam [3:0] ST_LOST_FRAME = 4'h7;
	localparam [3:0] ST_PEND_DEACT = 4'h8;
	localparam [3:0] ST_LOOP_CLOSE = 4'h9;
	localparam [3:0] ST_LOOP_ACT   = 4'hA;
	localparam [3:0] ST_TEST       = 4'hB;
	localparam [3:0] ST_WAIT_DC    = 4'hC;
	localparam [3:0] ST_G2_PEND    = 4'hD;
	localparam [3:0] ST_G2_LOST    = 4'hE;
	localparam [31:0] INFO0_LIM    = INFO0_WAIT_CYC;
	localparam [31:0] DEACT_LIM    = DEACT_TIMER_CYC;
	localparam [7:0]  INFO1_PAT    = `L1CI_INFO1_PATTERN;

	// ==========================================
	// command latch
	wire [3:0] cmd_w;
	wire       cmd_new_w;

	l1ci_cmd_filter u_cmd_filter (
		.clock_i        (clock_i),
		.srst_i         (srst_i),
		.frame_strobe_i (frame_strobe_i),
		.cmd_code_i     (cmd_code_i),
		.cmd_latched_o  (cmd_w),
		.cmd_new_o      (cmd_new_w)
	);

	// ==========================================
	// receive classification
	reg [1:0] rx_class;
	always @* begin
		if (!rx_signal_i)
			rx_class = `L1CI_RX_INFO0;
		else if (rx_sync_i && !rx_a_bit_i)
			rx_class = `L1CI_RX_INFO2;
		else if (rx_sync_i && rx_a_bit_i)
			rx_class = `L1CI_RX_INFO4;
		else
			rx_class = `L1CI_RX_INFOX;
	end

	wire cmd_act_w  = (cmd_w == `L1CI_CMD_ACT_PRIO_LOW) || (cmd_w == `L1CI_CMD_ACT_PRIO_HIGH) ||
	                  (cmd_w == `L1CI_CMD_ACT_LOOPBACK);
	wire cmd_test_w = (cmd_w == `L1CI_CMD_SINGLE_PULSE) || (cmd_w == `L1CI_CMD_CONT_PULSE);

	// ==========================================
	// state, timers, indication
	reg [3:0]  state_q, state_d;
	reg [3:0]  ind_d;
	reg [31:0] info0_cnt_q;
	reg [31:0] deact_cnt_q;
	reg        test_cont_q;
	reg [2:0]  bit_idx_q;

	wire info0_done_w = (info0_cnt_q >= INFO0_LIM);
	wire deact_done_w = (deact_cnt_q >= DEACT_LIM);

	always @* begin
		state_d = state_q;
		ind_d   = ind_code_o;
		// unconditional commands first; test mode is never re-entered from itself
		if (cmd_new_w && cmd_w == `L1CI_CMD_FSM_RESET) begin
			state_d = ST_RESET;
		end else if (cmd_new_w && cmd_test_w && state_q != ST_TEST) begin
			state_d = ST_TEST;
		end else if (!line_term_mode_i && cmd_new_w && cmd_w == `L1CI_CMD_ACT_LOOPBACK &&
		             state_q != ST_LOOP_CLOSE && state_q != ST_LOOP_ACT) begin
			state_d = ST_LOOP_CLOSE;
		end else if (line_term_mode_i) begin
			case (state_q)
				ST_RESET, ST_TEST, ST_WAIT_DC: begin
					if (cmd_w == `L1CI_CMD_DEACT_CONFIRM && cmd_new_w)
						state_d = ST_DEACT;
				end
				ST_DEACT, ST_POWER_UP: begin
					if (rx_class == `L1CI_RX_INFO0 && rx_signal_i == 1'b0 && cmd_new_w &&
					    (cmd_w == `L1CI_CMD_ACT_REQ_DOWN || cmd_w == `L1CI_CMD_ACT_LOOPBACK))
						state_d = ST_G2_PEND;
					else if (rx_signal_i)
						state_d = ST_G2_PEND;
				end
				ST_G2_PEND, ST_G2_LOST: begin
					if (cmd_new_w && cmd_w == `L1CI_CMD_DEACT_REQUEST)
						state_d = ST_PEND_DEACT;
					else if (rx_sync_i)
						state_d = ST_ACTIVE;
				end
				ST_ACTIVE: begin
					if (cmd_new_w && cmd_w == `L1CI_CMD_DEACT_REQUEST)
						state_d = ST_PEND_DEACT;
					else if (!rx_sync_i)
						state_d = ST_G2_LOST;
				end
				ST_PEND_DEACT: begin
					if (info0_done_w || deact_done_w)
						state_d = ST_WAIT_DC;
				end
				default: state_d = ST_DEACT;
			endcase
		end else begin
			case (state_q)
				ST_RESET, ST_TEST: begin
					if (cmd_new_w && cmd_w == `L1CI_CMD_DEACT_IND)
						state_d = ST_DEACT;
				end
				ST_DEACT: begin
					if (cmd_w == `L1CI_CMD_CLOCK_REQUEST)
						state_d = ST_POWER_UP;
					else if (cmd_act_w)
						state_d = ST_PEND_ACT;
					else if (rx_class == `L1CI_RX_INFO2)
						state_d = ST_SYNC;
					else if (rx_class == `L1CI_RX_INFO4)
						state_d = ST_ACTIVE;
				end
				ST_POWER_UP, ST_PEND_ACT, ST_UNSYNC: begin
					if (cmd_new_w && cmd_w == `L1CI_CMD_DEACT_IND)
						state_d = ST_DEACT;
					else if (cmd_act_w && state_q == ST_POWER_UP)
						state_d = ST_PEND_ACT;
					else if (rx_class == `L1CI_RX_INFO2)
						state_d = ST_SYNC;
					else if (rx_class == `L1CI_RX_INFO4)
						state_d = ST_ACTIVE;
					else if (rx_class == `L1CI_RX_INFOX)
						state_d = ST_UNSYNC;
				end
				ST_SYNC: begin
					if (rx_class == `L1CI_RX_INFO0)
						state_d = ST_PEND_DEACT;
					else if (rx_class == `L1CI_RX_INFO4)
						state_d = ST_ACTIVE;
					else if (rx_class == `L1CI_RX_INFOX)
						state_d = ST_LOST_FRAME;
				end
				ST_ACTIVE, ST_LOST_FRAME: begin
					if (rx_class == `L1CI_RX_INFO0)
						state_d = ST_PEND_DEACT;
					else if (rx_class == `L1CI_RX_INFO2)
						state_d = ST_SYNC;
					else if (rx_class == `L1CI_RX_INFO4)
						state_d = ST_ACTIVE;
					else
						state_d = ST_LOST_FRAME;
				end
				ST_PEND_DEACT: begin
					if (cmd_new_w && cmd_w == `L1CI_CMD_DEACT_IND)
						state_d = ST_DEACT;
				end
				ST_LOOP_CLOSE: begin
					if (cmd_w != `L1CI_CMD_ACT_LOOPBACK)
						state_d = ST_DEACT;
					else if (rx_sync_i)
						state_d = ST_LOOP_ACT;
				end
				ST_LOOP_ACT: begin
					if (cmd_w != `L1CI_CMD_ACT_LOOPBACK)
						state_d = ST_DEACT;
					else if (!rx_sync_i)
						state_d = ST_LOOP_CLOSE;
				end
				default: state_d = ST_DEACT;
			endcase
		end

		case (state_d)
			ST_RESET:      ind_d = `L1CI_IND_RESET_ACK;
			ST_TEST:       ind_d = `L1CI_IND_TEST_MODE_ACK;
			ST_DEACT:      ind_d = `L1CI_IND_DEACT_CONFIRM;
			ST_POWER_UP:   ind_d = line_term_mode_i ? `L1CI_IND_DEACT_CONFIRM : `L1CI_IND_POWERED_UP;
			ST_PEND_ACT:   ind_d = `L1CI_IND_DEACT_CONFIRM;
			ST_UNSYNC:     ind_d = `L1CI_IND_RECV_UNSYNC;
			ST_SYNC:       ind_d = `L1CI_IND_ACT_REQUEST;
			ST_ACTIVE:     ind_d = line_term_mode_i ? `L1CI_IND_ACT_PRIO_LOW :
			                       (rx_high_prio_i ? `L1CI_IND_ACT_PRIO_HIGH : `L1CI_IND_ACT_PRIO_LOW);
			ST_LOST_FRAME: ind_d = `L1CI_IND_RECV_UNSYNC;
			// line side: interim code while the timers run, so the final one marks expiry
			ST_PEND_DEACT: ind_d = line_term_mode_i ? `L1CI_IND_DEACT_REQUEST :
			                       (state_q == ST_SYNC ? `L1CI_IND_DEACT_FROM_SYNC :
			                        (state_q == ST_PEND_DEACT ? ind_code_o : `L1CI_IND_DEACT_REQUEST));
			ST_LOOP_CLOSE: ind_d = `L1CI_IND_LOOP_CLOSED;
			ST_LOOP_ACT:   ind_d = `L1CI_IND_LOOP_ACTIVATED;
			ST_WAIT_DC:    ind_d = `L1CI_IND_DEACT_CONFIRM;
			ST_G2_PEND:    ind_d = `L1CI_IND_ACT_REQUEST;
			ST_G2_LOST:    ind_d = `L1CI_IND_RECV_UNSYNC;
			default:       ind_d = `L1CI_IND_DEACT_CONFIRM;
		endcase
		// a violation report overrides in every state but reset and test while reporting is on
		if (rx_illegal_viol_i && illegal_violation_enable_i && state_d != ST_RESET && state_d != ST_TEST)
			ind_d = `L1CI_IND_ILLEGAL_VIOL;
	end

	// ==========================================
	// registers
	always @(posedge clock_i) begin
		if (srst_i) begin
			state_q          <= ST_RESET;
			ind_code_o       <= `L1CI_IND_RESET_ACK;
			info0_cnt_q      <= 32'h0;
			deact_cnt_q      <= 32'h0;
			test_cont_q      <= 1'b0;
			bit_idx_q        <= 3'h0;
			tx_info_o        <= `L1CI_TX_INFO0;
			tx_pattern_bit_o <= 1'b0;
			loop_closed_o    <= 1'b0;
			loop_tx_blank_o  <= 1'b0;
			transparent_o    <= 1'b0;
			clocks_enable_o  <= 1'b1;
		end else begin
			state_q <= state_d;
			// held code goes out on every frame slot until the state, the priority or a violation report changes it
			ind_code_o <= ind_d;
			if (state_q == ST_PEND_DEACT && line_term_mode_i) begin
				deact_cnt_q <= deact_cnt_q + 32'h1;
				info0_cnt_q <= rx_signal_i ? 32'h0 : info0_cnt_q + 32'h1;
			end else begin
				deact_cnt_q <= 32'h0;
				info0_cnt_q <= 32'h0;
			end
			if (cmd_new_w && cmd_test_w)
				test_cont_q <= (cmd_w == `L1CI_CMD_CONT_PULSE);
			bit_idx_q <= bit_idx_q + 3'h1;
			tx_pattern_bit_o <= INFO1_PAT[3'h7 - bit_idx_q];
			case (state_d)
				// a fresh test command decides; the held flag may be from the previous test
				ST_TEST:       tx_info_o <= ((cmd_new_w && cmd_test_w) ? (cmd_w == `L1CI_CMD_CONT_PULSE) :
				                            test_cont_q) ? `L1CI_TX_CONT_PULSE : `L1CI_TX_SINGLE_PULSE;
				ST_PEND_ACT:   tx_info_o <= `L1CI_TX_INFO1;
				ST_SYNC, ST_ACTIVE, ST_LOOP_CLOSE, ST_LOOP_ACT:
				               tx_info_o <= line_term_mode_i ? `L1CI_TX_INFO4 : `L1CI_TX_INFO3;
				ST_G2_PEND, ST_G2_LOST:
				               tx_info_o <= `L1CI_TX_INFO2;
				default:       tx_info_o <= `L1CI_TX_INFO0;
			endcase
			loop_closed_o   <= (state_d == ST_LOOP_CLOSE) || (state_d == ST_LOOP_ACT) ||
			                   (line_term_mode_i && state_d == ST_G2_PEND && cmd_w == `L1CI_CMD_ACT_LOOPBACK);
			loop_tx_blank_o <= transmit_disable_i && ((state_d == ST_LOOP_CLOSE) || (state_d == ST_LOOP_ACT));
			// on the terminal side, dropping the request for two frames in a row blocks the user channels
			transparent_o   <= ((state_d == ST_ACTIVE) || (state_d == ST_LOOP_ACT)) &&
			                   (line_term_mode_i || cmd_act_w);
			clocks_enable_o <= !(clock_shutdown_select_i && state_d == ST_DEACT &&
			                     (cmd_w != `L1CI_CMD_CLOCK_REQUEST));
		end
	end
endmodule
`default_nettype wire

// *** src/l1ci_consts.vh ***
`ifndef L1CI_CONSTS_VH
`define L1CI_CONSTS_VH
// ==========================================
// command codes, terminal side
`define L1CI_CMD_CLOCK_REQUEST   4'h0
`define L1CI_CMD_FSM_RESET       4'h1
`define L1CI_CMD_SINGLE_PULSE    4'h2
`define L1CI_CMD_CONT_PULSE      4'h3
`define L1CI_CMD_ACT_PRIO_LOW    4'h8
`define L1CI_CMD_ACT_PRIO_HIGH   4'h9
`define L1CI_CMD_ACT_LOOPBACK    4'hA
`define L1CI_CMD_DEACT_IND       4'hF
// ==========================================
// command codes, line-termination side
`define L1CI_CMD_DEACT_REQUEST   4'h0
`define L1CI_CMD_ACT_REQ_DOWN    4'h8
`define L1CI_CMD_DEACT_CONFIRM   4'hF
// ==========================================
// indication codes
`define L1CI_IND_DEACT_REQUEST   4'h0
`define L1CI_IND_RESET_ACK       4'h1
`define L1CI_IND_TEST_MODE_ACK   4'h2
`define L1CI_IND_RECV_UNSYNC     4'h4
`define L1CI_IND_DEACT_FROM_SYNC 4'h5
`define L1CI_IND_POWERED_UP      4'h7
`define L1CI_IND_ACT_REQUEST     4'h8
`define L1CI_IND_LOOP_CLOSED     4'hA
`define L1CI_IND_ILLEGAL_VIOL    4'hB
`define L1CI_IND_ACT_PRIO_LOW    4'hC
`define L1CI_IND_ACT_PRIO_HIGH   4'hD
`define L1CI_IND_LOOP_ACTIVATED  4'hE
`define L1CI_IND_DEACT_CONFIRM   4'hF
// ==========================================
// receive info classes
`define L1CI_RX_INFO0            2'h0
`define L1CI_RX_INFO2            2'h1
`define L1CI_RX_INFO4            2'h2
`define L1CI_RX_INFOX            2'h3
// ==========================================
// transmit info select
`define L1CI_TX_INFO0            3'h0
`define L1CI_TX_INFO1            3'h1
`define L1CI_TX_INFO2            3'h2
`define L1CI_TX_INFO3            3'h3
`define L1CI_TX_INFO4            3'h4
`define L1CI_TX_SINGLE_PULSE     3'h5
`define L1CI_TX_CONT_PULSE       3'h6
// ==========================================
// line patterns and timing
`define L1CI_INFO1_PATTERN       8'h3F
`define L1CI_CLK_HZ              25000000
`define L1CI_INFO0_WAIT_MS       16
`define L1CI_DEACT_TIMER_MS      32
`define L1CI_INFO0_WAIT_CYC      ((`L1CI_CLK_HZ / 1000) * `L1CI_INFO0_WAIT_MS)
`define L1CI_DEACT_TIMER_CYC     ((`L1CI_CLK_HZ / 1000) * `L1CI_DEACT_TIMER_MS)
`define L1CI_CMD_STABLE_FRAMES   2'h2
`endif

// *** src/l1ci_cmd_filter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "l1ci_consts.vh"
// ==========================================
// command latch: a code must be seen on consecutive frames
module l1ci_cmd_filter (
	input  wire       clock_i,
	input  wire       srst_i,
	input  wire       frame_strobe_i,
	input  wire [3:0] cmd_code_i,
	output reg  [3:0] cmd_latched_o,
	output reg        cmd_new_o
);
	reg [3:0] last_q;
	reg [1:0] same_q;

	always @(posedge clock_i) begin
		if (srst_i) begin
			last_q        <= 4'hF;
			same_q        <= 2'h0;
			cmd_latched_o <= 4'hF;
			cmd_new_o     <= 1'b0;
		end else begin
			cmd_new_o <= 1'b0;
			if (frame_strobe_i) begin
				last_q <= cmd_code_i;
				if (cmd_code_i != last_q) begin
					same_q <= 2'h1;
				end else if (same_q != `L1CI_CMD_STABLE_FRAMES) begin
					same_q <= same_q + 2'h1;
					// glitch rejection: one odd frame never reaches the machine
					if (same_q + 2'h1 == `L1CI_CMD_STABLE_FRAMES) begin
						cmd_latched_o <= cmd_code_i;
						cmd_new_o     <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/l1ci_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// layer-2 controller: one code per frame, held as a level
module l1ci_ctrl_model #(
	parameter int FRAME_CYC = 6
) (
	input  wire logic       clock_i,
	input  wire logic       srst_i,
	input  wire logic [3:0] cmd_i,
	output var  logic       frame_strobe_o,
	output var  logic [3:0] cmd_code_o
);
	int cnt_q;
	initial begin
		cnt_q = 0;
		frame_strobe_o = 1'b0;
		cmd_code_o = 4'hF;
	end
	// short frames keep the run small, the latch only counts strobes
	always @(negedge clock_i) begin
		frame_strobe_o <= 1'b0;
		if (srst_i) begin
			cnt_q <= 0;
		end else if (cnt_q == FRAME_CYC - 1) begin
			cnt_q <= 0;
			frame_strobe_o <= 1'b1;
			if ((cmd_i[3:1] == 3'h1) && (cmd_code_o[3:1] == 3'h1) && (cmd_i != cmd_code_o)) begin
				cmd_code_o <= 4'hF; // no direct chain of pulse
			end else begin
				cmd_code_o <= cmd_i; // repeated every frame
			end
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule
`default_nettype wire

// *** verification/l1ci_fsm_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks of the activation machine
module l1ci_fsm_properties #(
	parameter INFO0_WAIT_CYC  = 16,
	parameter DEACT_TIMER_CYC = 32
) (
	input wire logic       clock_i,
	input wire logic       srst_i,
	input wire logic       line_term_mode_i,
	input wire logic       frame_strobe_i,
	input wire logic [3:0] cmd_code_i,
	input wire logic       rx_signal_i,
	input wire logic       rx_sync_i,
	input wire logic       rx_a_bit_i,
	input wire logic       rx_high_prio_i,
	input wire logic       rx_illegal_viol_i,
	input wire logic       illegal_violation_enable_i,
	input wire logic       transmit_disable_i,
	input wire logic       clock_shutdown_select_i,
	input wire logic [3:0] ind_code_o,
	input wire logic [2:0] tx_info_o,
	input wire logic       tx_pattern_bit_o,
	input wire logic       loop_closed_o,
	input wire logic       loop_tx_blank_o,
	input wire logic       transparent_o,
	input wire logic       clocks_enable_o
);
	wire logic te_w = !line_term_mode_i;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	reset_vals_a: assert property (disable iff (1'b0)
		srst_i |=> ind_code_o == 4'h1 && tx_info_o == 3'h0 && !loop_closed_o && !transparent_o && clocks_enable_o)
		else $error("outputs not at reset values");
	viol_shown_a: assert property (
		(illegal_violation_enable_i && rx_illegal_viol_i)[*2] |-> ind_code_o == 4'hB) else $error("violation not shown");
	viol_masked_a: assert property (
		!illegal_violation_enable_i[*2] |-> ind_code_o != 4'hB) else $error("violation shown while masked");
	test_ack_a: assert property (
		te_w && !rx_illegal_viol_i && !$past(rx_illegal_viol_i) |->
		(ind_code_o == 4'h2) == (tx_info_o == 3'h5 || tx_info_o == 3'h6)) else $error("test ack and pulses differ");
	info1_period_a: assert property (
		(tx_info_o == 3'h1)[*8] ##1 (tx_info_o == 3'h1)[*2] |-> tx_pattern_bit_o == $past(tx_pattern_bit_o, 8))
		else $error("pattern period not 8");
	transp_act_a: assert property (
		te_w && transparent_o |-> ind_code_o inside {4'hB, 4'hC, 4'hD, 4'hE}) else $error("transparent outside activation");
	loop_ind_a: assert property (
		te_w && loop_closed_o |-> ind_code_o inside {4'h4, 4'hA, 4'hB, 4'hE}) else $error("loop without loop code");
	clk_off_a: assert property (
		!clocks_enable_o |-> ind_code_o == 4'hF && $past(clock_shutdown_select_i)) else $error("clocks off wrongly");
	lt_resync_a: assert property (
		line_term_mode_i && tx_info_o == 3'h4 && !rx_sync_i |-> ##[1:4] tx_info_o != 3'h4) else $error("no info2 on lost sync");
	lt_act_ind_a: assert property (
		line_term_mode_i && tx_info_o == 3'h4 |-> ##[0:2] ind_code_o == 4'hC) else $error("line side not activated");
	cover property (ind_code_o == 4'hD);
	cover property (tx_info_o == 3'h6);
	cover property (line_term_mode_i && ind_code_o == 4'hF);
endmodule
bind l1ci_fsm l1ci_fsm_properties #(.INFO0_WAIT_CYC(INFO0_WAIT_CYC), .DEACT_TIMER_CYC(DEACT_TIMER_CYC)) u_props (
	.clock_i(clock_i), .srst_i(srst_i), .line_term_mode_i(line_term_mode_i), .frame_strobe_i(frame_strobe_i),
	.cmd_code_i(cmd_code_i), .rx_signal_i(rx_signal_i), .rx_sync_i(rx_sync_i), .rx_a_bit_i(rx_a_bit_i),
	.rx_high_prio_i(rx_high_prio_i), .rx_illegal_viol_i(rx_illegal_viol_i),
	.illegal_violation_enable_i(illegal_violation_enable_i), .transmit_disable_i(transmit_disable_i),
	.clock_shutdown_select_i(clock_shutdown_select_i), .ind_code_o(ind_code_o), .tx_info_o(tx_info_o),
	.tx_pattern_bit_o(tx_pattern_bit_o), .loop_closed_o(loop_closed_o), .loop_tx_blank_o(loop_tx_blank_o),
	.transparent_o(transparent_o), .clocks_enable_o(clocks_enable_o));
`default_nettype wire

// *** verification/layer1_ci_code_activation_fsm_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module layer1_ci_code_activation_fsm_tb;
	logic       clock_i, srst_i, lt_mode, rx_sig, rx_syn, rx_a, rx_hi, rx_viol, viol_en, tx_dis, clock_shutdown_select;
	logic       strobe, pat_bit, loop_cl, loop_blank, transp, clk_en;
	logic [3:0] cmd_req, cmd_code, ind_code;
	logic [2:0] tx_info;
	int         n_fail, cmp_count;
	l1ci_ctrl_model #(.FRAME_CYC(6)) u_ctrl (.clock_i(clock_i), .srst_i(srst_i), .cmd_i(cmd_req),
		.frame_strobe_o(strobe), .cmd_code_o(cmd_code));
	l1ci_fsm #(.INFO0_WAIT_CYC(16), .DEACT_TIMER_CYC(32)) dut (
		.clock_i(clock_i), .srst_i(srst_i), .line_term_mode_i(lt_mode), .frame_strobe_i(strobe),
		.cmd_code_i(cmd_code), .rx_signal_i(rx_sig), .rx_sync_i(rx_syn), .rx_a_bit_i(rx_a),
		.rx_high_prio_i(rx_hi), .rx_illegal_viol_i(rx_viol), .illegal_violation_enable_i(viol_en),
		.transmit_disable_i(tx_dis), .clock_shutdown_select_i(clock_shutdown_select), .ind_code_o(ind_code),
		.tx_info_o(tx_info), .tx_pattern_bit_o(pat_bit), .loop_closed_o(loop_cl),
		.loop_tx_blank_o(loop_blank), .transparent_o(transp), .clocks_enable_o(clk_en));
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// ==========================================
	// helpers
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] pick(input int k);
		case (k)
			0: pick = {4'h0, ind_code};
			1: pick = {5'h0, tx_info};
			2: pick = {7'h0, loop_cl};
			3: pick = {7'h0, transp};
			4: pick = {7'h0, clk_en};
			default: pick = {7'h0, loop_blank};
		endcase
	endfunction
	// bound covers a code latch plus the longest line-side timer
	task automatic expect_out(input string nm, input int k, input logic [7:0] exp);
		int i;
		for (i = 0; i < 400 && pick(k) !== exp; i++) @(negedge clock_i);
		check(nm, pick(k), exp);
		if (i == 400) stop_test();
	endtask
	// two frames to latch, two edges to answer
	task automatic send(input logic [3:0] c);
		@(negedge clock_i);
		cmd_req = c;
		repeat (14) @(negedge clock_i);
	endtask
	task automatic rx(input logic s, input logic y, input logic a);
		@(negedge clock_i);
		{rx_sig, rx_syn, rx_a} = {s, y, a};
	endtask
	task automatic do_reset(input logic lt);
		@(negedge clock_i);
		lt_mode = lt;
		srst_i = 1'b1;
		repeat (8) @(negedge clock_i);
		srst_i = 1'b0;
	endtask
	// ==========================================
	// scenarios
	task automatic t_power();
		do_reset(1'b0);
		check("ind", pick(0), 8'h01);
		check("tx", pick(1), 8'h00);
		clock_shutdown_select = 1'b1;
		send(4'hF);
		expect_out("ind", 0, 8'h0F);
		expect_out("clk", 4, 8'h00);
		send(4'h0);
		expect_out("clk", 4, 8'h01);
		expect_out("ind", 0, 8'h07);
		clock_shutdown_select = 1'b0;
	endtask
	task automatic t_act();
		int i;
		logic [7:0] b;
		b = 8'h00;
		send(4'h8);
		expect_out("tx", 1, 8'h01);
		for (i = 0; i < 20 && !(b[0] === 1'b1 && pat_bit === 1'b0); i++) begin
			b[0] = pat_bit;
			@(negedge clock_i);
		end
		for (i = 0; i < 8; i++) begin
			b = {b[6:0], pat_bit};
			@(negedge clock_i);
		end
		check("pattern", b, 8'h3F);
		rx(1'b1, 1'b1, 1'b0);
		expect_out("ind", 0, 8'h08);
		expect_out("tx", 1, 8'h03);
		rx(1'b1, 1'b1, 1'b1);
		expect_out("ind", 0, 8'h0C);
		expect_out("transp", 3, 8'h01);
		rx_hi = 1'b1;
		send(4'h9);
		expect_out("ind", 0, 8'h0D);
		send(4'h0);
		expect_out("transp", 3, 8'h00);
		rx(1'b0, 1'b0, 1'b0);
		rx_hi = 1'b0;
		expect_out("ind", 0, 8'h00);
		send(4'hF);
		expect_out("ind", 0, 8'h0F);
	endtask
	task automatic t_sync();
		send(4'h0);
		expect_out("ind", 0, 8'h07);
		rx(1'b1, 1'b0, 1'b0);
		expect_out("ind", 0, 8'h04);
		rx(1'b1, 1'b1, 1'b0);
		expect_out("ind", 0, 8'h08);
		rx(1'b0, 1'b0, 1'b0);
		expect_out("ind", 0, 8'h05);
		send(4'h0);
		send(4'hF);
		expect_out("ind", 0, 8'h0F);
	endtask
	task automatic t_viol();
		@(negedge clock_i);
		{viol_en, rx_viol} = 2'b11;
		expect_out("ind", 0, 8'h0B);
		viol_en = 1'b0;
		expect_out("ind", 0, 8'h0F);
		rx_viol = 1'b0;
	endtask
	task automatic t_test();
		send(4'h3);
		expect_out("ind", 0, 8'h02);
		expect_out("tx", 1, 8'h06);
		send(4'hF); // leave test mode before the other pulse
		expect_out("ind", 0, 8'h0F);
		send(4'h2);
		expect_out("ind", 0, 8'h02);
		expect_out("tx", 1, 8'h05);
		send(4'hF);
	endtask
	task automatic t_loop();
		tx_dis = 1'b1;
		send(4'hA);
		expect_out("ind", 0, 8'h0A);
		expect_out("loop", 2, 8'h01);
		expect_out("blank", 5, 8'h01);
		rx(1'b1, 1'b1, 1'b0);
		expect_out("ind", 0, 8'h0E);
		send(4'h1);
		expect_out("ind", 0, 8'h01);
		expect_out("loop", 2, 8'h00);
		rx(1'b0, 1'b0, 1'b0);
		tx_dis = 1'b0;
	endtask
	task automatic t_line();
		int i;
		do_reset(1'b1);
		send(4'hF);
		send(4'h8);
		expect_out("tx", 1, 8'h02);
		rx(1'b1, 1'b1, 1'b0);
		expect_out("tx", 1, 8'h04);
		expect_out("ind", 0, 8'h0C);
		rx(1'b1, 1'b0, 1'b0);
		expect_out("tx", 1, 8'h02);
		rx(1'b1, 1'b1, 1'b0);
		expect_out("tx", 1, 8'h04);
		rx(1'b0, 1'b0, 1'b0);
		@(negedge clock_i);
		cmd_req = 4'h0;
		expect_out("ind", 0, 8'h00);
		for (i = 0; i < 40 && ind_code !== 4'hF; i++) @(negedge clock_i);
		check("info0 wait", {7'h0, i < 20}, 8'h01);
		repeat (60) @(negedge clock_i);
		check("ind", pick(0), 8'h0F);
	endtask
	initial begin
		srst_i = 1'b1;
		{lt_mode, rx_sig, rx_syn, rx_a, rx_hi, rx_viol, viol_en, tx_dis, clock_shutdown_select} = '0;
		cmd_req = 4'hF;
		n_fail = 0;
		cmp_count = 0;
		t_power();
		t_act();
		t_sync();
		t_viol();
		t_test();
		t_loop();
		t_line();
		stop_test();
	end
endmodule
`default_nettype wire
